// ### verilog/parameter_command_interpreter.sv
// Purpose: Text command interpreter for reading and parameter operating modes
// Assumes: Terminal and host receivers deliver bytes on clk_in with valid/ready
// Notes: One command is handled at a time; the port that starts a string owns it
`timescale 1ns/100ps
`default_nettype none
module parameter_command_interpreter
  import cmd_interp_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       term_valid_in,
  input  wire logic [7:0] term_data_in,
  output logic            term_ready_out,
  input  wire logic       host_valid_in,
  input  wire logic [7:0] host_data_in,
  output logic            host_ready_out,
  output logic            tx_valid_out,
  output logic [7:0]      tx_data_out,
  output logic            tx_port_out,
  input  wire logic       tx_ready_in,
  output logic            param_mode_out,
  output logic            ready_led_out
);

  param_if pif ();

  param_store #(.WORDS(PARAM_WORDS)) u_store (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .pif      (pif)
  );

  state_t     state_q, state_d;
  logic       mode_q, mode_d;
  logic       led_q, led_d;
  logic       port_q, port_d;
  logic       lock_q, lock_d;
  logic       ovf_q, ovf_d;
  logic [3:0] len_q, len_d;
  logic [7:0] buf_q [CMD_MAX];
  logic [7:0] buf_d [CMD_MAX];
  logic [7:0] rsp_q [RSP_MAX];
  logic [7:0] rsp_d [RSP_MAX];
  logic [3:0] rsp_len_q, rsp_len_d;
  logic [3:0] rd_addr_q, rd_addr_d;
  logic [2:0] rd_left_q, rd_left_d;
  logic       rd_wait_q, rd_wait_d;

  // Either port may start a string; terminal wins a tie when both are idle
  assign term_ready_out = (state_q == ST_RECV) && (!lock_q || !port_q);
  assign host_ready_out = (state_q == ST_RECV) && (lock_q ? port_q : !term_valid_in);

  logic       term_take, host_take, take;
  logic [7:0] rx_byte;
  assign term_take = term_valid_in && term_ready_out;
  assign host_take = host_valid_in && host_ready_out;
  assign take      = term_take || host_take;
  assign rx_byte   = term_take ? term_data_in : host_data_in;

  logic [7:0] b0, b1, b2, b3;
  logic [3:0] blen;
  logic [4:0] h1, h2, h3;
  logic       prefix_ok, is_mp, is_mr, is_eew, is_set, is_lt, is_qry, good;

  // In parameter mode the body follows the leading '3'
  always_comb begin
    b0        = mode_q ? buf_q[1] : buf_q[0];
    b1        = mode_q ? buf_q[2] : buf_q[1];
    b2        = mode_q ? buf_q[3] : buf_q[2];
    b3        = mode_q ? buf_q[4] : buf_q[3];
    blen      = mode_q ? len_q - 4'h1 : len_q;
    h1        = hex_val(b1);
    h2        = hex_val(b2);
    h3        = hex_val(b3);
    prefix_ok = !ovf_q && (!mode_q || (len_q != 4'h0 && buf_q[0] == CH_3));
    is_mp     = prefix_ok && blen == 4'h2 && b0 == CH_M && b1 == CH_P;
    is_mr     = prefix_ok && blen == 4'h2 && b0 == CH_M && b1 == CH_R;
    is_eew    = mode_q && prefix_ok && blen == 4'h3 && b0 == CH_E && b1 == CH_E && b2 == CH_W;
    is_set    = mode_q && prefix_ok && blen == 4'h4 && b0 == CH_S && h1[4] && h2[4] && h3[4];
    is_lt     = mode_q && prefix_ok && blen == 4'h3 && b0 == CH_QM && b1 == CH_L && b2 == CH_T;
    is_qry    = mode_q && prefix_ok && blen == 4'h2 && b0 == CH_QM && h1[4];
    good      = is_mp || is_mr || is_eew || is_set || is_lt || is_qry;
  end

  always_comb begin
    state_d   = state_q;
    mode_d    = mode_q;
    port_d    = port_q;
    lock_d    = lock_q;
    ovf_d     = ovf_q;
    len_d     = len_q;
    buf_d     = buf_q;
    rsp_d     = rsp_q;
    rsp_len_d = rsp_len_q;
    rd_addr_d = rd_addr_q;
    rd_left_d = rd_left_q;
    rd_wait_d = rd_wait_q;
    pif.wr_en     = 1'b0;
    pif.addr      = rd_addr_q;
    pif.wdata     = {h2[3:0], h3[3:0]};
    pif.store_req = 1'b0;
    unique case (state_q)
      ST_LOAD: begin
        if (!pif.busy) begin
          state_d = ST_RECV;
        end
      end
      ST_RECV: begin
        if (take) begin
          if (!lock_d) begin
            port_d = host_take;
          end
          lock_d = 1'b1;
          if (rx_byte == CH_CR) begin
            state_d = ST_EXEC;
          end else if (len_q < 4'(CMD_MAX)) begin
            buf_d[len_q] = rx_byte;
            len_d        = len_q + 4'h1;
          end else begin
            ovf_d = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        for (int i = 0; i < CMD_MAX; i++) begin
          rsp_d[i] = buf_q[i];
        end
        rsp_d[len_q] = CH_CR;
        rsp_len_d    = len_q + 4'h1;
        state_d      = ST_REPLY;
        if (!good) begin
          state_d = ST_RECV;
          lock_d  = 1'b0;
          ovf_d   = 1'b0;
          len_d   = LEN_RESET;
        end else if (is_mp) begin
          mode_d = 1'b1;
        end else if (is_mr) begin
          mode_d = 1'b0;
        end else if (is_set) begin
          pif.wr_en = 1'b1;
          pif.addr  = h1[3:0];
        end else if (is_eew) begin
          pif.store_req = 1'b1;
          state_d       = ST_STORE;
        end else begin
          // Query replies are "3" + identifier + hex digits; the reads append the digits
          rsp_d[0]  = CH_3;
          rsp_d[1]  = is_lt ? CH_L : CH_S;
          rsp_d[2]  = is_lt ? CH_T : b1;
          rsp_len_d = 4'h3;
          rd_addr_d = is_lt ? PULSE_BASE : h1[3:0];
          rd_left_d = is_lt ? 3'(PULSE_WORDS) : 3'h1;
          rd_wait_d = 1'b0;
          state_d   = ST_READ;
        end
      end
      ST_READ: begin
        rd_wait_d = !rd_wait_q;
        if (rd_wait_q) begin
          rsp_d[rsp_len_q]        = hex_char(pif.rdata[7:4]);
          rsp_d[rsp_len_q + 4'h1] = hex_char(pif.rdata[3:0]);
          rsp_len_d               = rsp_len_q + 4'h2;
          rd_addr_d               = rd_addr_q + 4'h1;
          rd_left_d               = rd_left_q - 3'h1;
          if (rd_left_q == 3'h1) begin
            rsp_d[rsp_len_q + 4'h2] = CH_CR;
            rsp_len_d               = rsp_len_q + 4'h3;
            state_d                 = ST_REPLY;
          end
        end
      end
      ST_STORE: begin
        // Echo is held back until the nonvolatile copy has finished
        if (!pif.busy) begin
          state_d = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (tx_ready_in) begin
          for (int i = 0; i < RSP_MAX - 1; i++) begin
            rsp_d[i] = rsp_q[i + 1];
          end
          rsp_len_d = rsp_len_q - 4'h1;
          if (rsp_len_q == 4'h1) begin
            state_d = ST_RECV;
            lock_d  = 1'b0;
            ovf_d   = 1'b0;
            len_d   = LEN_RESET;
          end
        end
      end
      default: begin
        state_d = ST_RECV;
      end
    endcase
    led_d = !mode_d && (state_d != ST_LOAD);
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q   <= ST_LOAD;
      mode_q    <= 1'b0;
      led_q     <= 1'b0;
      port_q    <= 1'b0;
      lock_q    <= 1'b0;
      ovf_q     <= 1'b0;
      len_q     <= LEN_RESET;
      rsp_len_q <= LEN_RESET;
      rd_addr_q <= PULSE_BASE;
      rd_left_q <= 3'h0;
      rd_wait_q <= 1'b0;
      for (int i = 0; i < CMD_MAX; i++) begin
        buf_q[i] <= WORD_RESET;
      end
      for (int i = 0; i < RSP_MAX; i++) begin
        rsp_q[i] <= WORD_RESET;
      end
    end else begin
      state_q   <= state_d;
      mode_q    <= mode_d;
      led_q     <= led_d;
      port_q    <= port_d;
      lock_q    <= lock_d;
      ovf_q     <= ovf_d;
      len_q     <= len_d;
      rsp_len_q <= rsp_len_d;
      rd_addr_q <= rd_addr_d;
      rd_left_q <= rd_left_d;
      rd_wait_q <= rd_wait_d;
      buf_q     <= buf_d;
      rsp_q     <= rsp_d;
    end
  end

  assign tx_valid_out   = (state_q == ST_REPLY);
  assign tx_data_out    = rsp_q[0];
  assign tx_port_out    = port_q;
  assign param_mode_out = mode_q;
  assign ready_led_out  = led_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_either_port_taken: assert property (
    state_q == ST_RECV && !lock_q && host_valid_in && !term_valid_in |-> host_ready_out)
    else $error("host port refused while idle");

  a_cr_executes_now: assert property (
    take && rx_byte == CH_CR |=> state_q == ST_EXEC)
    else $error("command end not executed at once");

  a_param_entry_led: assert property (
    state_q == ST_EXEC && is_mp |=> param_mode_out && !ready_led_out)
    else $error("parameter mode entry left ready indicator on");

  a_reading_entry_led: assert property (
    state_q == ST_EXEC && is_mr |=> !param_mode_out && ready_led_out)
    else $error("reading mode entry left ready indicator off");

  a_good_cmd_echo: assert property (
    state_q == ST_EXEC && (is_mp || is_mr || is_set) |=> tx_valid_out && tx_data_out == $past(buf_q[0]))
    else $error("correct command not echoed");

  a_pulse_query_reply: assert property (
    state_q == ST_EXEC && is_lt |=> state_q == ST_READ [*8] ##1 tx_valid_out && tx_data_out == CH_3 ##0 rsp_len_q == 4'hC)
    else $error("pulse query reply wrong");

  a_bad_cmd_silent: assert property (
    state_q == ST_EXEC && !good |-> !pif.wr_en && !pif.store_req ##1 state_q == ST_RECV && !tx_valid_out)
    else $error("bad command acted on or echoed");

  a_load_before_recv: assert property (
    state_q == ST_LOAD && pif.busy |=> !term_ready_out && !host_ready_out && !ready_led_out)
    else $error("commands taken before parameter load");

endmodule
`default_nettype wire

// ### verilog/cmd_interp_pkg.sv
// Purpose: Shared constants, types and helpers of the parameter command interpreter
// Assumes: Bytes arrive from two serial receivers on the same clock as the interpreter
// Notes: Command strings end with carriage return; parameter values are 8-bit words
// Function
// - Accept commands on terminal and host ports
// - Execute each command when it completes
// - Changes go to working copy only
// - Store command copies working set to nonvolatile
// - Parameter mode entry drops ready indicator
// - Echo every correct command except queries, which get a reply instead
// - Pulse query returns encoded pulse parameters
// - Reading mode entry relights ready indicator
// - Power-up loads last stored parameter set
package cmd_interp_pkg;

  localparam int          CMD_MAX     = 12;
  localparam int          RSP_MAX     = CMD_MAX + 1;
  localparam int          PARAM_WORDS = 16;
  localparam int          PARAM_AW    = 4;
  localparam int          PULSE_WORDS = 4;
  localparam logic [3:0]  LEN_RESET   = 4'h0;
  localparam logic [7:0]  WORD_RESET  = 8'h00;
  localparam logic [3:0]  PULSE_BASE  = 4'h0;

  localparam logic [7:0]  CH_CR   = 8'h0D;
  localparam logic [7:0]  CH_3    = 8'h33;
  localparam logic [7:0]  CH_QM   = 8'h3F;
  localparam logic [7:0]  CH_S    = 8'h53;
  localparam logic [7:0]  CH_M    = 8'h4D;
  localparam logic [7:0]  CH_P    = 8'h50;
  localparam logic [7:0]  CH_R    = 8'h52;
  localparam logic [7:0]  CH_L    = 8'h4C;
  localparam logic [7:0]  CH_T    = 8'h54;
  localparam logic [7:0]  CH_E    = 8'h45;
  localparam logic [7:0]  CH_W    = 8'h57;

  typedef enum logic [2:0] {
    ST_LOAD  = 3'b000,
    ST_RECV  = 3'b001,
    ST_EXEC  = 3'b011,
    ST_READ  = 3'b010,
    ST_REPLY = 3'b110,
    ST_STORE = 3'b111
  } state_t;

  // Returns {valid, value} for an upper-case hex digit
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      return {1'b1, 4'(c - 8'h30)};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      return {1'b1, 4'(c - 8'h37)};
    end
    return 5'h00;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] v);
    return (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
  endfunction

endpackage

// ### verilog/param_if.sv
// Purpose: Connection between the command interpreter and the parameter store
// Assumes: Read data is registered and valid one cycle after addr is presented
// Notes: store_req is a one-cycle pulse taken only while busy is low
`timescale 1ns/100ps
`default_nettype none
interface param_if;
  logic       wr_en;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       store_req;
  logic       busy;

  modport ctrl (output wr_en, addr, wdata, store_req, input rdata, busy);
  modport mem  (input wr_en, addr, wdata, store_req, output rdata, busy);
endinterface
`default_nettype wire

// ### verilog/param_store.sv
// Purpose: Working parameter set plus nonvolatile copy with block copy engine
// Assumes: Nonvolatile array keeps its contents across reset_in, like an EEPROM
// Notes: Reset starts a nonvolatile-to-working copy; busy stays high until done
`timescale 1ns/100ps
`default_nettype none
module param_store
  import cmd_interp_pkg::*;
#(
  parameter int WORDS = PARAM_WORDS
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  param_if.mem      pif
);

  logic [7:0]          work_q [WORDS];
  logic [7:0]          nv_q   [WORDS];
  logic [7:0]          rdata_q;
  logic                busy_q, busy_d;
  logic                dir_store_q, dir_store_d;
  logic [PARAM_AW-1:0] cnt_q, cnt_d;

  always_comb begin
    busy_d      = busy_q;
    dir_store_d = dir_store_q;
    cnt_d       = cnt_q;
    if (busy_q) begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == PARAM_AW'(WORDS - 1)) begin
        busy_d = 1'b0;
      end
    end else if (pif.store_req) begin
      busy_d      = 1'b1;
      dir_store_d = 1'b1;
      cnt_d       = '0;
    end
  end

  // Power-up copy back from nonvolatile discards any unsaved changes
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_q      <= 1'b1;
      dir_store_q <= 1'b0;
      cnt_q       <= '0;
    end else begin
      busy_q      <= busy_d;
      dir_store_q <= dir_store_d;
      cnt_q       <= cnt_d;
    end
  end

  // Arrays are not reset: the working set is refilled by the copy engine
  always_ff @(posedge clk_in) begin
    if (busy_q && dir_store_q) begin
      nv_q[cnt_q] <= work_q[cnt_q];
    end else if (busy_q) begin
      work_q[cnt_q] <= nv_q[cnt_q];
    end else if (pif.wr_en) begin
      work_q[pif.addr] <= pif.wdata;
    end
    rdata_q <= work_q[pif.addr];
  end

  assign pif.rdata = rdata_q;
  assign pif.busy  = busy_q;

  logic                wr_seen_q;
  logic [PARAM_AW-1:0] wr_addr_q;
  logic [7:0]          wr_data_q;
  logic [7:0]          wr_nv_q;
  always_ff @(posedge clk_in) begin
    wr_seen_q <= pif.wr_en && !busy_q;
    wr_addr_q <= pif.addr;
    wr_data_q <= pif.wdata;
    wr_nv_q   <= nv_q[pif.addr];
  end

  // Case equality: the nonvolatile copy holds no defined value before the first store
  a_work_only_write: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_seen_q |-> work_q[wr_addr_q] == wr_data_q && nv_q[wr_addr_q] === wr_nv_q)
    else $error("working write lost or nonvolatile copy touched");

  // The copy takes exactly one cycle per word
  a_store_copy_len: assert property (@(posedge clk_in) disable iff (reset_in)
    pif.store_req && !busy_q |=> busy_q [*8] ##1 busy_q [*8] ##1 !busy_q)
    else $error("store copy length wrong");

endmodule
`default_nettype wire

// ### tb/serial_sender.sv
// Purpose: Host or terminal stand-in that sends command strings byte by byte
// Assumes: Called at a rising edge; ready is sampled at each rising edge
// Notes: Data is inverted after release so a stale byte never looks valid
`timescale 1ns/100ps
`default_nettype none
module serial_sender (
  input  wire logic       clk_in,
  output logic            valid_out,
  output logic [7:0]      data_out,
  input  wire logic       ready_in
);
  initial begin
    valid_out = 1'b0;
    data_out  = 8'h00;
  end

  // Caller supplies the leading '3' while the device is in parameter mode
  task automatic send(input string cmd);
    string s;
    s = {cmd, "\r"};
    for (int i = 0; i < s.len(); i++) begin
      valid_out <= 1'b1;
      data_out  <= s[i];
      do @(posedge clk_in); while (ready_in !== 1'b1);
    end
    valid_out <= 1'b0;
    data_out  <= ~data_out;
  endtask
endmodule
`default_nettype wire

// ### tb/test_parameter_command_interpreter.sv
// Purpose: Self-checking bench of the command interpreter against a queue model
// Assumes: Reply sink stalls at random from an LFSR; both ports carry commands
// Notes: Store is issued once before the power-up restore is exercised
`timescale 1ns/100ps
`default_nettype none
module test_parameter_command_interpreter;
  import cmd_interp_pkg::*;
  logic        clk_in;
  logic        reset_in;
  logic        term_valid_in;
  logic [7:0]  term_data_in;
  logic        term_ready_out;
  logic        host_valid_in;
  logic [7:0]  host_data_in;
  logic        host_ready_out;
  logic        tx_valid_out;
  logic [7:0]  tx_data_out;
  logic        tx_port_out;
  logic        tx_ready_in;
  logic        param_mode_out;
  logic        ready_led_out;
  logic [31:0] lfsr_q;
  logic [7:0]  exp_q[$];
  logic        exp_port;
  int          err_total;
  int          check_count;
  int          work[16];
  int          nv[16];

  parameter_command_interpreter u_dut (
    .clk_in(clk_in), .reset_in(reset_in),
    .term_valid_in(term_valid_in), .term_data_in(term_data_in), .term_ready_out(term_ready_out),
    .host_valid_in(host_valid_in), .host_data_in(host_data_in), .host_ready_out(host_ready_out),
    .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_port_out(tx_port_out),
    .tx_ready_in(tx_ready_in), .param_mode_out(param_mode_out), .ready_led_out(ready_led_out)
  );
  serial_sender u_term (.clk_in(clk_in), .valid_out(term_valid_in), .data_out(term_data_in),
                        .ready_in(term_ready_out));
  serial_sender u_host (.clk_in(clk_in), .valid_out(host_valid_in), .data_out(host_data_in),
                        .ready_in(host_ready_out));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic string hx(input int v, input int n);
    string r;
    int    d;
    r = "";
    for (int i = n - 1; i >= 0; i--) begin
      d = (v >> (4 * i)) & 15;
      r = {r, $sformatf("%c", (d < 10) ? 8'h30 + d : 8'h37 + d)};
    end
    return r;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Sends one string and waits for the whole reply, or none, to be seen
  task automatic run(input logic port, input string cmd, input string rsp);
    int i;
    for (i = 0; i < rsp.len(); i++) exp_q.push_back(rsp[i]);
    exp_port = port;
    @(posedge clk_in);
    if (port) u_host.send(cmd); else u_term.send(cmd);
    repeat (3) @(posedge clk_in);
    for (i = 0; i < 400 && (exp_q.size() != 0 || term_ready_out !== 1'b1); i++) @(posedge clk_in);
    check({7'h00, exp_q.size() == 0}, 8'h01);
  endtask

  task automatic wait_ready;
    int i;
    for (i = 0; i < 100 && term_ready_out !== 1'b1; i++) @(posedge clk_in);
    check({7'h00, term_ready_out}, 8'h01);
  endtask

  task automatic check_mode(input logic pm);
    check({7'h00, param_mode_out}, {7'h00, pm});
    check({7'h00, ready_led_out}, {7'h00, ~pm});
  endtask

  task automatic write_word(input logic port, input int a, input int v);
    string c;
    c = {"3S", hx(a, 1), hx(v, 2)};
    work[a] = v;
    run(port, c, {c, "\r"});
  endtask

  task automatic query(input int a);
    run(1'b0, {"3?", hx(a, 1)}, {"3S", hx(a, 1), hx(work[a], 2), "\r"});
  endtask

  // Reply sink: every accepted byte must be the next one the model expects
  always @(posedge clk_in) begin
    lfsr_q      <= lfsr_next(lfsr_q);
    tx_ready_in <= lfsr_q[0] | lfsr_q[3];
    if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
      check({7'h00, exp_q.size() != 0}, 8'h01);
      if (exp_q.size() != 0) begin
        check(tx_data_out, exp_q.pop_front());
        check({7'h00, tx_port_out}, {7'h00, exp_port});
      end
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    // Whole sequence needs under a thousand cycles; allow over twenty times that
    #200_000;
    err_total++;
    end_sim;
  end

  initial begin
    reset_in    = 1'b1;
    tx_ready_in = 1'b0;
    lfsr_q      = 32'h0000_d58d;
    err_total   = 0;
    check_count = 0;
    exp_port    = 1'b0;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    wait_ready();
    check_mode(1'b0);
    run(1'b0, "MR", "MR\r");
    run(1'b0, "MP", "MP\r");
    check_mode(1'b1);
    for (int a = 0; a < 4; a++) write_word(a[0], a, int'(lfsr_q[7:0]));
    write_word(1'b1, 15, int'(lfsr_q[15:8]));
    query(15);
    run(1'b1, "3?LT", {"3LT", hx(work[0], 2), hx(work[1], 2), hx(work[2], 2), hx(work[3], 2), "\r"});
    run(1'b0, "3EEW", "3EEW\r");
    nv = work;
    // Malformed strings: no prefix, lower case, bad digits, too long
    run(1'b0, "MP", "");
    run(1'b0, "3s0AA", "");
    run(1'b1, "3S0ZZ", "");
    run(1'b0, "3S0123456789AB", "");
    run(1'b0, "3Q", "");
    check_mode(1'b1);
    query(0);
    write_word(1'b0, 1, (work[1] + 8'h5A) & 255);
    query(1);
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    work = nv;
    wait_ready();
    check_mode(1'b0);
    run(1'b1, "MP", "MP\r");
    query(1);
    run(1'b1, "3MR", "3MR\r");
    check_mode(1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
